// ===== hw/seg_seq_pkg.sv
package seg_seq_pkg;

  // ------------------------------------------------------------------
  // Widths and identifiers
  // ------------------------------------------------------------------
  localparam int unsigned POS_W      = 32;
  localparam int unsigned ID_W       = 7;
  localparam int unsigned DEPTH      = 128;
  localparam logic [6:0]  ID_NONE    = 7'h00;
  localparam logic [6:0]  ID_SP_BUILTIN = 7'h0d;
  localparam logic [6:0]  ID_SEG_MIN = 7'h0e;
  localparam logic [6:0]  ID_SEG_MAX = 7'h7f;

  // ------------------------------------------------------------------
  // Programmable I/O word layout
  // ------------------------------------------------------------------
  localparam int unsigned PIO_W         = 16;
  localparam int unsigned PIO_FAULT_BIT = 8;
  localparam logic [15:0] PIO_DEFAULT   = 16'h0000;
  localparam logic [1:0]  OUT_RESET_VAL = 2'h0;

  // ------------------------------------------------------------------
  // Trigger select
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_NONE = 2'h0,
    TRIG_VEL  = 2'h1,
    TRIG_REL  = 2'h2,
    TRIG_ABS  = 2'h3
  } trig_kind_t;

  // Output action on trigger
  typedef enum logic [1:0] {
    OUT_KEEP  = 2'h0,
    OUT_SET   = 2'h1,
    OUT_CLR   = 2'h2,
    OUT_PULSE = 2'h3
  } out_act_t;

  // ------------------------------------------------------------------
  // Segment definition
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  next_id;
    out_act_t    out_act;
    logic [1:0]  out_sel;
    trig_kind_t  trig;
    logic [1:0]  in_trig;
    logic        trig_and;
    logic        incr;
    logic [31:0] pos;
    logic [31:0] trig_val;
  } seg_t;

  // Segment write port
  typedef struct packed {
    logic        valid;
    logic [6:0]  id;
    seg_t        seg;
  } seg_wr_t;

  // Command from the command block
  typedef struct packed {
    logic        valid;
    logic [6:0]  id;
    logic        hw_start;
    logic        axis_reset;
    logic        imm_stop;
    logic        slide_stop;
  } cmd_t;

  // Setpoint definition
  typedef struct packed {
    logic        incr;
    logic [31:0] pos;
  } setpt_t;

  // Motion state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARMED = 3'h1,
    ST_RUN   = 3'h3,
    ST_HOLD  = 3'h2,
    ST_STOP  = 3'h6
  } st_t;

endpackage

// ===== hw/seg_store.sv
`timescale 1ns/1ps
module seg_store #(
  parameter int unsigned DEPTH = seg_seq_pkg::DEPTH
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_clear,
  input  wire seg_seq_pkg::seg_wr_t i_wr,
  input  wire logic [6:0]          i_rd_id,
  output seg_seq_pkg::seg_t        o_seg,
  output logic                     o_defined
);

  seg_seq_pkg::seg_t mem [DEPTH];
  logic [DEPTH-1:0]  valid_reg;

  always_ff @(posedge i_clk) begin
    if (i_wr.valid) begin
      mem[i_wr.id] <= i_wr.seg;
    end
  end

  // Axis reset discards every definition
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_clear) begin
      valid_reg <= '0;
    end else if (i_wr.valid && i_wr.id >= seg_seq_pkg::ID_SEG_MIN) begin
      valid_reg[i_wr.id] <= 1'b1;
    end
  end

  assign o_seg     = mem[i_rd_id];
  assign o_defined = valid_reg[i_rd_id];

endmodule // seg_store

// ===== hw/motion_segment_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Host fault or program mode slide-stops an active or armed segment, not a setpoint move
// - Watchdog drives outputs to hold or reset
// - Axis reset discards segments and setpoint
// - Axis reset keeps the I/O configuration
// - Power-up restores default I/O configuration
// - Hardware start acts only on a segment armed by hw_start, ignored while moving
// - Hardware-start segment waits for rising edge
// - Chained segment starts at once
// - Incremental moves reference position at start
// - Incremental setpoint adds to previous endpoint
// - Setpoint command abandons chain, goes to endpoint
// - Untriggered segment finishes and holds endpoint
// - Immediate stop and slide stop honoured
// - Device never requests block order
// - Next id zero means slide stop
// - Segment ids 14 to 127 start motion
module motion_segment_sequencer #(
  parameter int unsigned POS_W = seg_seq_pkg::POS_W
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_host_fault,
  input  wire logic                 i_host_prog,
  input  wire logic                 i_hw_start,
  input  wire logic                 i_hw_stop,
  input  wire logic                 i_in1,
  input  wire logic                 i_in2,
  input  wire logic [POS_W-1:0]     i_act_pos,
  input  wire logic [POS_W-1:0]     i_act_vel,
  input  wire logic                 i_at_target,
  input  wire seg_seq_pkg::seg_wr_t i_seg_wr,
  input  wire logic                 i_sp_wr,
  input  wire seg_seq_pkg::setpt_t  i_sp,
  input  wire logic                 i_pio_wr,
  input  wire logic [15:0]          i_pio,
  input  wire seg_seq_pkg::cmd_t    i_cmd,
  output logic [POS_W-1:0]          o_target,
  output logic                      o_move,
  output logic                      o_slide_stop,
  output logic                      o_imm_stop,
  output logic [1:0]                o_prog_out,
  output logic                      o_seg_active,
  output logic [6:0]                o_active_id,
  output logic [15:0]               o_pio_cfg,
  output logic                      o_wdog
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       start_d_reg;
  logic [1:0] in_d_reg;
  always_ff @(posedge i_clk) begin
    sync1_reg <= {i_host_fault, i_host_prog, i_hw_start, i_hw_stop,
                  i_in1};
    sync2_reg <= sync1_reg;
  end
  logic host_bad;
  logic start_s;
  logic stop_s;
  logic [1:0] ins;
  assign host_bad = sync2_reg[4] | sync2_reg[3];
  assign start_s  = sync2_reg[2];
  assign stop_s   = sync2_reg[1];
  logic in2_1_reg;
  logic in2_2_reg;
  always_ff @(posedge i_clk) begin
    in2_1_reg <= i_in2;
    in2_2_reg <= in2_1_reg;
  end
  assign ins = {in2_2_reg, sync2_reg[0]};
  always_ff @(posedge i_clk) begin
    start_d_reg <= start_s;
    in_d_reg    <= ins;
  end
  logic start_rise;
  assign start_rise = start_s & ~start_d_reg;

  // ------------------------------------------------------------------
  // Segment store
  // ------------------------------------------------------------------
  seg_seq_pkg::seg_t seg;
  logic              seg_def;
  logic [6:0]        cur_id_reg;
  logic [6:0]        rd_id;
  logic              clr;
  assign clr = i_cmd.valid & i_cmd.axis_reset;

  seg_store u_store (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (clr),
    .i_wr      (i_seg_wr),
    .i_rd_id   (rd_id),
    .o_seg     (seg),
    .o_defined (seg_def)
  );

  function automatic logic is_seg(input logic [6:0] id);
    return id >= seg_seq_pkg::ID_SEG_MIN && id <= seg_seq_pkg::ID_SEG_MAX;
  endfunction

  // ------------------------------------------------------------------
  // Setpoint store and programmable I/O configuration
  // ------------------------------------------------------------------
  seg_seq_pkg::setpt_t sp_reg;
  logic                sp_valid_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || clr) begin
      sp_valid_reg <= 1'b0;
      sp_reg       <= '0;
    end else if (i_sp_wr) begin
      sp_valid_reg <= 1'b1;
      sp_reg       <= i_sp;
    end
  end

  // Only power-up reset touches the I/O word; axis reset does not
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pio_cfg <= seg_seq_pkg::PIO_DEFAULT;
    end else if (i_pio_wr) begin
      o_pio_cfg <= i_pio;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  seg_seq_pkg::st_t st_reg;
  seg_seq_pkg::st_t st_next;
  logic [POS_W-1:0] ref_reg;
  logic [POS_W-1:0] sp_end_reg;
  logic [1:0]       in_seen_reg;
  logic             pos_seen_reg;
  logic             cmd_seg;
  logic             cmd_sp;
  logic             stop_req;
  logic             slide_req;
  logic             wdog_hit;
  logic             trig_ok;
  logic             pos_hit;
  logic [1:0]       in_hit;
  logic [POS_W-1:0] thr;
  logic             running;

  assign running  = st_reg == seg_seq_pkg::ST_RUN;
  assign cmd_seg  = i_cmd.valid & ~i_cmd.axis_reset & is_seg(i_cmd.id);
  assign cmd_sp   = i_cmd.valid & ~i_cmd.axis_reset & ~is_seg(i_cmd.id)
                    & (i_cmd.id != seg_seq_pkg::ID_NONE);
  assign stop_req = stop_s | (i_cmd.valid & i_cmd.imm_stop);
  assign slide_req = i_cmd.valid & i_cmd.slide_stop;
  assign wdog_hit = host_bad & o_seg_active;
  assign rd_id    = cur_id_reg;

  // Position/velocity trigger: reached or crossed
  always_comb begin
    thr = seg.trig_val;
    if (seg.trig == seg_seq_pkg::TRIG_REL) begin
      thr = seg.trig_val + ref_reg;
    end
    case (seg.trig)
      seg_seq_pkg::TRIG_VEL: begin
        pos_hit = (i_act_vel[POS_W-1] ? -i_act_vel : i_act_vel) >= thr;
      end
      seg_seq_pkg::TRIG_REL,
      seg_seq_pkg::TRIG_ABS: begin
        pos_hit = ($signed(thr) >= $signed(ref_reg))
                  ? $signed(i_act_pos) >= $signed(thr)
                  : $signed(i_act_pos) <= $signed(thr);
      end
      default: pos_hit = 1'b0;
    endcase
  end

  assign in_hit = seg.in_trig & (in_seen_reg | ins);
  always_comb begin
    logic p;
    logic any_act;
    p       = (seg.trig == seg_seq_pkg::TRIG_NONE) ? 1'b0
              : (pos_seen_reg | pos_hit);
    any_act = (seg.trig != seg_seq_pkg::TRIG_NONE) | (|seg.in_trig);
    if (!any_act) begin
      trig_ok = 1'b0;
    end else if (seg.trig_and) begin
      trig_ok = ((seg.trig == seg_seq_pkg::TRIG_NONE) | p)
                & (in_hit == seg.in_trig);
    end else begin
      trig_ok = p | (|in_hit);
    end
  end

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      seg_seq_pkg::ST_IDLE,
      seg_seq_pkg::ST_HOLD: begin
        if (cmd_seg) begin
          st_next = i_cmd.hw_start ? seg_seq_pkg::ST_ARMED
                                   : seg_seq_pkg::ST_RUN;
        end
      end
      seg_seq_pkg::ST_ARMED: begin
        if (start_rise) begin
          st_next = seg_seq_pkg::ST_RUN;
        end
      end
      seg_seq_pkg::ST_RUN: begin
        if (trig_ok && seg.next_id == seg_seq_pkg::ID_NONE) begin
          st_next = seg_seq_pkg::ST_STOP;
        end else if (!trig_ok && i_at_target) begin
          st_next = seg_seq_pkg::ST_HOLD;
        end
      end
      seg_seq_pkg::ST_STOP: begin
        if (i_at_target) begin
          st_next = seg_seq_pkg::ST_IDLE;
        end
      end
      default: st_next = seg_seq_pkg::ST_IDLE;
    endcase
    if (wdog_hit || slide_req) begin
      st_next = seg_seq_pkg::ST_STOP;
    end
    if (stop_req || cmd_sp || clr || !seg_def && running) begin
      st_next = seg_seq_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= seg_seq_pkg::ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Active id, reference capture and trigger memory
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cur_id_reg   <= seg_seq_pkg::ID_NONE;
      ref_reg      <= '0;
      in_seen_reg  <= '0;
      pos_seen_reg <= 1'b0;
    end else if (st_next == seg_seq_pkg::ST_RUN &&
                 (st_reg != seg_seq_pkg::ST_RUN)) begin
      if (cmd_seg) begin
        cur_id_reg <= i_cmd.id;
      end
      ref_reg      <= i_act_pos;
      in_seen_reg  <= '0;
      pos_seen_reg <= 1'b0;
    end else if (running && trig_ok &&
                 seg.next_id != seg_seq_pkg::ID_NONE) begin
      cur_id_reg   <= seg.next_id;
      ref_reg      <= i_act_pos;
      in_seen_reg  <= '0;
      pos_seen_reg <= 1'b0;
    end else if (running) begin
      in_seen_reg  <= in_seen_reg | in_hit;
      pos_seen_reg <= pos_seen_reg | pos_hit;
    end else if (cmd_seg) begin
      cur_id_reg <= i_cmd.id;
    end
  end

  // Setpoint endpoint chain
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || clr) begin
      sp_end_reg <= '0;
    end else if (cmd_sp && sp_valid_reg) begin
      sp_end_reg <= sp_reg.incr ? sp_end_reg + sp_reg.pos
                                : sp_reg.pos;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_target     <= '0;
      o_move       <= 1'b0;
      o_slide_stop <= 1'b0;
      o_imm_stop   <= 1'b0;
      o_seg_active <= 1'b0;
      o_active_id  <= seg_seq_pkg::ID_NONE;
      o_wdog       <= 1'b0;
    end else begin
      o_move       <= (st_next == seg_seq_pkg::ST_RUN) | cmd_sp;
      o_slide_stop <= st_next == seg_seq_pkg::ST_STOP;
      o_imm_stop   <= stop_req;
      o_seg_active <= (st_next == seg_seq_pkg::ST_RUN) |
                      (st_next == seg_seq_pkg::ST_ARMED);
      o_active_id  <= cur_id_reg;
      o_wdog       <= wdog_hit | (o_wdog & host_bad);
      if (cmd_sp && sp_valid_reg) begin
        o_target <= sp_reg.incr ? sp_end_reg + sp_reg.pos
                                : sp_reg.pos;
      end else if (running) begin
        o_target <= seg.incr ? ref_reg + seg.pos : seg.pos;
      end
    end
  end

  // Programmable outputs, with fault state on watchdog
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || clr) begin
      o_prog_out <= seg_seq_pkg::OUT_RESET_VAL;
    end else if (wdog_hit) begin
      if (!o_pio_cfg[seg_seq_pkg::PIO_FAULT_BIT]) begin
        o_prog_out <= seg_seq_pkg::OUT_RESET_VAL;
      end
    end else if (running && trig_ok) begin
      case (seg.out_act)
        seg_seq_pkg::OUT_SET:   o_prog_out <= o_prog_out | seg.out_sel;
        seg_seq_pkg::OUT_CLR:   o_prog_out <= o_prog_out & ~seg.out_sel;
        seg_seq_pkg::OUT_PULSE: o_prog_out <= o_prog_out ^ seg.out_sel;
        default:                o_prog_out <= o_prog_out;
      endcase
    end
  end

endmodule // motion_segment_sequencer

// ===== testbench/motion_segment_sequencer_asserts.sv
`timescale 1ns/1ps
module motion_segment_sequencer_asserts (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_host_fault,
  input wire logic              i_host_prog,
  input wire logic              i_hw_start,
  input wire logic              i_hw_stop,
  input wire logic              i_pio_wr,
  input wire seg_seq_pkg::cmd_t i_cmd,
  input wire logic              o_move,
  input wire logic              o_slide_stop,
  input wire logic              o_imm_stop,
  input wire logic [1:0]        o_prog_out,
  input wire logic              o_seg_active,
  input wire logic [15:0]       o_pio_cfg,
  input wire logic              o_wdog
);
  // ----
  // Checks
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire bad = i_host_fault | i_host_prog;
  wire rst_cmd = i_cmd.valid & i_cmd.axis_reset;

  AST_PIO_KEEP:
    assert property (rst_cmd && !i_pio_wr |=> $stable(o_pio_cfg))
    else $error("io config changed by axis reset");
  AST_CLR:
    assert property (rst_cmd |=> ##[0:1] !o_seg_active)
    else $error("segment active after axis reset");
  AST_HOLD_OFF:
    assert property ((o_seg_active && !o_move && !i_cmd.valid
      && !i_hw_start) [*5] |=> !o_move)
    else $error("armed segment moved without start edge");
  AST_WDOG:
    assert property ($rose(bad) && o_seg_active |-> ##[1:4] o_wdog)
    else $error("watchdog missed host fault");
  AST_WDOG_SLIDE:
    assert property ($rose(o_wdog) |-> ##[0:1] o_slide_stop)
    else $error("watchdog gave no slide stop");
  AST_FAULT_HOLD:
    assert property (o_wdog && $past(o_wdog) && o_pio_cfg[8]
      && !$past(i_cmd.valid) |-> $stable(o_prog_out))
    else $error("outputs moved while held on fault");
  AST_FAULT_RESET:
    assert property ($rose(o_wdog) && !o_pio_cfg[8]
      |-> ##[0:1] o_prog_out == seg_seq_pkg::OUT_RESET_VAL)
    else $error("outputs not reset on fault");
  AST_IMM_STOP:
    assert property ($rose(i_hw_stop) && o_seg_active
      |-> ##[1:4] o_imm_stop)
    else $error("hardware stop not honoured");

  cover property ($rose(o_move));
  cover property ($rose(o_wdog));
  cover property ($rose(o_slide_stop));
endmodule // motion_segment_sequencer_asserts

bind motion_segment_sequencer motion_segment_sequencer_asserts u_chk (
  .i_clk, .i_rst_n, .i_host_fault, .i_host_prog, .i_hw_start,
  .i_hw_stop, .i_pio_wr, .i_cmd, .o_move, .o_slide_stop, .o_imm_stop,
  .o_prog_out, .o_seg_active, .o_pio_cfg, .o_wdog
);

// ===== testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic            i_clk,
  input  wire logic            i_seg_active,
  output seg_seq_pkg::seg_wr_t o_seg_wr,
  output logic                 o_sp_wr,
  output seg_seq_pkg::setpt_t  o_sp,
  output logic                 o_pio_wr,
  output logic [15:0]          o_pio,
  output seg_seq_pkg::cmd_t    o_cmd
);
  // ----
  // Block writes, one path chosen per call
  // ----
  logic [3:0] poll_cnt = 4'h0;
  logic       seen_active;
  initial begin
    o_seg_wr = '0;
    {o_sp_wr, o_sp, o_pio_wr, o_pio} = '0;
    o_cmd = '0;
  end
  // Status read at a fixed interval
  always @(posedge i_clk) begin
    poll_cnt <= poll_cnt + 4'h1;
    if (poll_cnt == 4'h0) seen_active <= i_seg_active;
  end
  // Caller keeps config, setpoint, segment, command order
  task automatic put_pio(input logic [15:0] w);
    @(posedge i_clk);
    #1 {o_pio_wr, o_pio} = {1'b1, w};
    @(posedge i_clk);
    #1 {o_pio_wr, o_pio} = {1'b0, ~w};
  endtask
  // Optional when only segments are commanded
  task automatic put_sp(input logic inc, input logic [31:0] p);
    @(posedge i_clk);
    #1 {o_sp_wr, o_sp} = {1'b1, inc, p};
    @(posedge i_clk);
    #1 {o_sp_wr, o_sp} = {1'b0, ~inc, ~p};
  endtask
  task automatic put_seg(input logic [6:0] id,
                         input seg_seq_pkg::seg_t s);
    @(posedge i_clk);
    #1 o_seg_wr = {1'b1, id, s};
    @(posedge i_clk);
    #1 o_seg_wr = {1'b0, ~id, ~s};
  endtask
  task automatic put_cmd(input logic [6:0] id, input logic [3:0] f);
    @(posedge i_clk);
    #1 o_cmd = {1'b1, id, f};
    @(posedge i_clk);
    #1 o_cmd = {1'b0, ~id, ~f};
  endtask
endmodule // host_model

// ===== testbench/test_motion_segment_sequencer.sv
`timescale 1ns/1ps
module test_motion_segment_sequencer;
  localparam logic [1:0] VEL = seg_seq_pkg::TRIG_VEL;
  logic                 i_clk = 1'b0, i_rst_n = 1'b0, i_hw_stop = 1'b0;
  logic                 i_hw_start = 1'b0, i_at_target = 1'b0;
  logic                 i_host_fault = 1'b0, i_host_prog = 1'b0;
  logic [31:0]          i_act_pos = 32'h0, i_act_vel = 32'h0, o_target;
  logic                 o_move, o_slide_stop, o_imm_stop, o_seg_active;
  logic                 o_wdog, i_sp_wr, i_pio_wr;
  logic [1:0]           o_prog_out;
  logic [6:0]           o_active_id;
  logic [15:0]          o_pio_cfg, i_pio;
  seg_seq_pkg::seg_wr_t i_seg_wr;
  seg_seq_pkg::setpt_t  i_sp;
  seg_seq_pkg::cmd_t    i_cmd;
  int                   error_cnt = 0, checks_done = 0, h;

  always #25 i_clk = ~i_clk;

  host_model host (.i_clk, .i_seg_active (o_seg_active),
    .o_seg_wr (i_seg_wr), .o_sp_wr (i_sp_wr), .o_sp (i_sp),
    .o_pio_wr (i_pio_wr), .o_pio (i_pio), .o_cmd (i_cmd));
  motion_segment_sequencer dut (.i_in1 (1'b0), .i_in2 (1'b0), .*);

  // ----
  // Helpers
  // ----
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wt(input string n, ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) step(1);
    chk(n, v, s);
    if (s !== v) close_out();
  endtask
  function automatic seg_seq_pkg::seg_t mk(input logic [6:0] nx,
      input logic [3:0] os, input logic [1:0] tg, input logic inc,
      input logic [31:0] p);
    return {nx, os, tg, 3'h0, inc, p, 32'h5};
  endfunction
  task automatic do_reset();
    i_rst_n = 1'b0;
    step(5);
    i_rst_n = 1'b1;
  endtask
  task automatic restart(input logic [15:0] w);
    host.put_cmd(7'h00, 4'h4);
    {i_at_target, i_act_vel, i_act_pos} = {1'b0, 32'h0, 32'h3e8};
    host.put_pio(w);
  endtask
  task automatic run14(input logic [3:0] f);
    host.put_seg(7'h0e, mk(7'h00, 4'h0, 2'h0, 1'b0, 32'h64));
    host.put_cmd(7'h0e, f);
  endtask
  task automatic pulse_start();
    i_hw_start = 1'b1;
    step(1);
    i_hw_start = 1'b0;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic sc_power();
    host.put_pio(16'h0100);
    do_reset();
    chk("pio_cfg", 32'h0, o_pio_cfg);
  endtask
  task automatic sc_axis_reset();
    host.put_pio(16'h0120);
    host.put_seg(7'h0e, mk(7'h00, 4'h0, 2'h0, 1'b0, 32'h64));
    host.put_cmd(7'h00, 4'h4);
    step(2);
    chk("pio_kept", 32'h0120, o_pio_cfg);
    host.put_cmd(7'h0e, 4'h0);
    step(4);
    chk("cleared_move", 32'h0, o_move);
  endtask
  task automatic sc_hw_start();
    restart(16'h0000);
    run14(4'h8);
    step(8);
    chk("armed_move", 32'h0, o_move);
    chk("armed", 32'h1, o_seg_active);
    pulse_start();
    wt("move", o_move, 1'b1);
    i_at_target = 1'b1;
    step(6);
    chk("hold_target", 32'h64, o_target);
    chk("hold_slide", 32'h0, o_slide_stop);
  endtask
  task automatic sc_chain();
    restart(16'h0000);
    host.put_seg(7'h0f, mk(7'h10, 4'h0, VEL, 1'b1, 32'h14));
    host.put_seg(7'h10, mk(7'h00, 4'h0, VEL, 1'b0, 32'h12c));
    host.put_cmd(7'h0f, 4'h8);
    pulse_start();
    wt("move", o_move, 1'b1);
    i_act_pos = 32'h7d0;
    step(3);
    chk("incr_target", 32'h3fc, o_target);
    i_act_vel = 32'ha;
    wt("chain_slide", o_slide_stop, 1'b1);
    chk("active_id", 32'h10, {25'h0, o_active_id});
    i_at_target = 1'b1;
    wt("slide_end", o_slide_stop, 1'b0);
  endtask
  task automatic sc_setpoint();
    restart(16'h0000);
    host.put_sp(1'b0, 32'h2bc);
    run14(4'h0);
    wt("move", o_move, 1'b1);
    host.put_cmd(7'h01, 4'h0);
    wt("chain_off", o_seg_active, 1'b0);
    chk("sp_target", 32'h2bc, o_target);
    host.put_sp(1'b1, 32'h5);
    host.put_cmd(7'h01, 4'h0);
    step(3);
    chk("incr_sp", 32'h2c1, o_target);
  endtask
  task automatic sc_watchdog();
    for (h = 0; h < 2; h++) begin
      restart({7'h00, h[0], 8'h00});
      host.put_seg(7'h14, mk(7'h15, 4'h7, VEL, 1'b0, 32'h190));
      host.put_seg(7'h15, mk(7'h00, 4'h0, 2'h0, 1'b0, 32'h1f4));
      host.put_cmd(7'h14, 4'h0);
      wt("move", o_move, 1'b1);
      i_act_vel = 32'ha;
      step(4);
      chk("outs_set", 32'h3, o_prog_out);
      {i_host_fault, i_host_prog} = {~h[0], h[0]};
      wt("wdog", o_wdog, 1'b1);
      wt("wd_slide", o_slide_stop, 1'b1);
      chk("fault_outs", h[0] ? 32'h3 : 32'h0, o_prog_out);
      {i_host_fault, i_host_prog} = 2'h0;
    end
  endtask
  task automatic sc_stop();
    for (h = 0; h < 3; h++) begin
      restart(16'h0000);
      run14(4'h0);
      wt("move", o_move, 1'b1);
      if (h == 0) i_hw_stop = 1'b1;
      else host.put_cmd(7'h00, h == 1 ? 4'h2 : 4'h1);
      if (h < 2) wt("imm", o_imm_stop, 1'b1);
      else wt("slide", o_slide_stop, 1'b1);
      i_hw_stop = 1'b0;
    end
  endtask

  initial begin
    do_reset();
    sc_power();
    sc_axis_reset();
    sc_hw_start();
    sc_chain();
    sc_setpoint();
    sc_watchdog();
    sc_stop();
    close_out();
  end
endmodule // test_motion_segment_sequencer
